//--- src/mrb_defs.vh
`ifndef MRB_DEFS_VH
`define MRB_DEFS_VH
// ----------------------------------------
// widths
// ----------------------------------------
`define MRB_ADDR_W 13
`define MRB_COL_W 12
`define MRB_SYNC_W 21
// ----------------------------------------
// base configuration fields
// ----------------------------------------
`define MRB_BL_LSB 0
`define MRB_BL_MSB 2
`define MRB_BT_BIT 3
`define MRB_CL_LSB 4
`define MRB_CL_MSB 6
`define MRB_OPM_LSB 7
`define MRB_OPM_MSB 12
`define MRB_OPM_NORMAL 6'h00
`define MRB_OPM_DLLRST 6'h02
// ----------------------------------------
// extended configuration fields
// ----------------------------------------
`define MRB_EXT_DLLDIS_BIT 0
`define MRB_EXT_DRIVE_BIT 1
`define MRB_EXT_RSV_LSB 2
`define MRB_EXT_RSV_MSB 12
`define MRB_EXT_RSV_ZERO 11'h000
// ----------------------------------------
// codes
// ----------------------------------------
`define MRB_BL_2 3'h1
`define MRB_BL_4 3'h2
`define MRB_BL_8 3'h3
`define MRB_LEN_2 4'h2
`define MRB_LEN_4 4'h4
`define MRB_LEN_8 4'h8
`define MRB_LEN_NONE 4'h0
`define MRB_CL_2 3'h2
`define MRB_CL_25 3'h6
`define MRB_CL_3 3'h3
`define MRB_BA_BASE 2'h0
`define MRB_BA_EXT 2'h1
// ----------------------------------------
// timing, in link clock edges
// ----------------------------------------
// first data: half-clock edges after the read or write command edge
`define MRB_HALF_CL_2 3'h2
`define MRB_HALF_CL_25 3'h3
`define MRB_HALF_CL_3 3'h4
`define MRB_HALF_WRITE 3'h2
`define MRB_DLL_LOCK_CK 8'hC8
`define MRB_MODE_WAIT_CK 2'h2
`endif

//--- src/mrb_burst_seq.v
`timescale 1ns/10ps
`include "mrb_defs.vh"
module mrb_burst_seq (
   input wire sysClk,
   input wire rstn,
   input wire start,
   input wire step,
   input wire [`MRB_COL_W-1:0] startCol,
   input wire [3:0] burstLen,
   input wire interleaved,
   output reg [`MRB_COL_W-1:0] column,
   output reg active,
   output reg last
);
   reg [2:0] count;
   reg [`MRB_COL_W-1:0] baseCol;
   reg [3:0] len;
   reg inter;
   wire [2:0] next_count;

   // ----------------------------------------
   // column order within the block
   // ----------------------------------------
   function [`MRB_COL_W-1:0] orderCol;
      input [`MRB_COL_W-1:0] col;
      input [2:0] cnt;
      input [3:0] bl;
      input ilv;
      reg [2:0] mask;
      reg [2:0] idx;
      begin
         mask = bl[2:0] - 3'h1;
         if (bl == `MRB_LEN_8) begin
            mask = 3'h7;
         end
         if (ilv) begin
            idx = col[2:0] ^ cnt;
         end else begin
            idx = col[2:0] + cnt;
         end
         // wrap inside the block, upper bits stay put
         orderCol = {col[`MRB_COL_W-1:3], (col[2:0] & ~mask) | (idx & mask)};
      end
   endfunction

   assign next_count = count + 3'h1;

   always @(posedge sysClk) begin
      if (!rstn) begin
         count <= 3'h0;
         baseCol <= {`MRB_COL_W{1'b0}};
         len <= `MRB_LEN_NONE;
         inter <= 1'b0;
         column <= {`MRB_COL_W{1'b0}};
         active <= 1'b0;
         last <= 1'b0;
      end else if (start && burstLen != `MRB_LEN_NONE) begin
         count <= 3'h0;
         baseCol <= startCol;
         len <= burstLen;
         inter <= interleaved;
         column <= orderCol(startCol, 3'h0, burstLen, interleaved);
         active <= 1'b1;
         last <= 1'b0;
      end else if (step && active) begin
         // the length bounds how many columns one command touches
         // compare the current index: a 3-bit next count never reaches eight
         if ({1'b0, count} == len - 4'h1) begin
            active <= 1'b0;
            last <= 1'b1;
         end else begin
            count <= next_count;
            column <= orderCol(baseCol, next_count, len, inter);
            last <= 1'b0;
         end
      end else begin
         last <= 1'b0;
      end
   end
endmodule

//--- src/mrb_config.v
`timescale 1ns/10ps
`include "mrb_defs.vh"
module mrb_config (
   input wire sysClk,
   input wire rstn,
   input wire ck,
   input wire cke,
   input wire csN,
   input wire rasN,
   input wire casN,
   input wire weN,
   input wire bank_select_low,
   input wire bank_select_high,
   input wire [`MRB_ADDR_W-1:0] addr,
   output reg [`MRB_ADDR_W-1:0] base_configuration,
   output reg [`MRB_ADDR_W-1:0] extended_configuration,
   output reg [3:0] burstLen,
   output reg interleaved,
   output reg [2:0] latencyHalf,
   output reg normalMode,
   output reg dllResetActive,
   output reg reservedMode,
   output reg dllEnabled,
   output reg dllLocked,
   output reg output_drive_select,
   output reg selfRefresh,
   output reg protocolError,
   output wire [`MRB_COL_W-1:0] burstColumn,
   output wire burstActive,
   output wire burstLast,
   output reg burstIsRead
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg [`MRB_SYNC_W-1:0] sync1;
   reg [`MRB_SYNC_W-1:0] sync2;
   reg [`MRB_SYNC_W-1:0] sync3;
   reg ckLevel;
   reg ckeLevel;
   wire ckStable;
   wire ckRise;
   wire ckFall;
   wire halfEdge;
   wire [`MRB_ADDR_W-1:0] sAddr;
   wire [1:0] sBank;
   wire sCke;
   wire sCs;
   wire sRas;
   wire sCas;
   wire sWe;
   wire cmdLoad;
   wire cmdRead;
   wire cmdWrite;
   wire cmdRefresh;
   wire cmdActive;
   wire cmdOther;
   reg [2:0] startDelay;
   reg startPending;
   reg [`MRB_COL_W-1:0] pendCol;
   reg pendRead;
   reg seqStart;
   reg [7:0] lockCount;
   reg [1:0] waitCount;

   // ----------------------------------------
   // field decoders
   // ----------------------------------------
   function [3:0] decodeLen;
      input [2:0] code;
      begin
         case (code)
            `MRB_BL_2: decodeLen = `MRB_LEN_2;
            `MRB_BL_4: decodeLen = `MRB_LEN_4;
            `MRB_BL_8: decodeLen = `MRB_LEN_8;
            default: decodeLen = `MRB_LEN_NONE;
         endcase
      end
   endfunction

   function [2:0] decodeLatency;
      input [2:0] code;
      begin
         case (code)
            `MRB_CL_2: decodeLatency = `MRB_HALF_CL_2;
            `MRB_CL_25: decodeLatency = `MRB_HALF_CL_25;
            `MRB_CL_3: decodeLatency = `MRB_HALF_CL_3;
            default: decodeLatency = `MRB_HALF_CL_3;
         endcase
      end
   endfunction

   // ----------------------------------------
   // sampling the link clock and command pins
   // ----------------------------------------
   // command pins share the clock's pipeline so they stay aligned to its edge
   always @(posedge sysClk) begin
      if (!rstn) begin
         sync1 <= {`MRB_SYNC_W{1'b0}};
         sync2 <= {`MRB_SYNC_W{1'b0}};
         sync3 <= {`MRB_SYNC_W{1'b0}};
      end else begin
         sync1 <= {ck, cke, csN, rasN, casN, weN, bank_select_high, bank_select_low, addr};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign ckStable = (sync2[`MRB_SYNC_W-1] == sync3[`MRB_SYNC_W-1]);
   assign ckRise = ckStable && sync3[`MRB_SYNC_W-1] && !ckLevel;
   assign ckFall = ckStable && !sync3[`MRB_SYNC_W-1] && ckLevel;
   assign halfEdge = ckRise || ckFall;
   assign sCke = sync3[`MRB_SYNC_W-2];
   assign sCs = !sync3[`MRB_SYNC_W-3];
   assign sRas = !sync3[`MRB_SYNC_W-4];
   assign sCas = !sync3[`MRB_SYNC_W-5];
   assign sWe = !sync3[`MRB_SYNC_W-6];
   assign sBank = sync3[`MRB_ADDR_W+1:`MRB_ADDR_W];
   assign sAddr = sync3[`MRB_ADDR_W-1:0];

   always @(posedge sysClk) begin
      if (!rstn) begin
         ckLevel <= 1'b0;
      end else if (ckStable) begin
         ckLevel <= sync3[`MRB_SYNC_W-1];
      end
   end

   // ----------------------------------------
   // command decode at the rising edge
   // ----------------------------------------
   assign cmdLoad = ckRise && ckeLevel && sCs && sRas && sCas && sWe;
   assign cmdRead = ckRise && ckeLevel && sCs && !sRas && sCas && !sWe;
   assign cmdWrite = ckRise && ckeLevel && sCs && !sRas && sCas && sWe;
   assign cmdRefresh = ckRise && sCs && sRas && sCas && !sWe;
   assign cmdActive = ckRise && ckeLevel && sCs && (sRas || sCas || sWe);
   assign cmdOther = cmdActive && !cmdLoad;

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   // no power-on value exists; reset gives a quiet, known state
   always @(posedge sysClk) begin
      if (!rstn) begin
         base_configuration <= {`MRB_ADDR_W{1'b0}};
         extended_configuration <= {`MRB_ADDR_W{1'b0}};
      end else if (cmdLoad) begin
         if (sBank == `MRB_BA_BASE) begin
            base_configuration <= sAddr;
         end else if (sBank == `MRB_BA_EXT) begin
            extended_configuration <= sAddr;
         end
      end
   end

   // decoded views, held in flops
   always @(posedge sysClk) begin
      if (!rstn) begin
         burstLen <= `MRB_LEN_NONE;
         interleaved <= 1'b0;
         latencyHalf <= `MRB_HALF_CL_3;
         normalMode <= 1'b0;
         dllResetActive <= 1'b0;
         reservedMode <= 1'b0;
         output_drive_select <= 1'b0;
      end else begin
         burstLen <= decodeLen(base_configuration[`MRB_BL_MSB:`MRB_BL_LSB]);
         interleaved <= base_configuration[`MRB_BT_BIT];
         latencyHalf <= decodeLatency(base_configuration[`MRB_CL_MSB:`MRB_CL_LSB]);
         normalMode <= (base_configuration[`MRB_OPM_MSB:`MRB_OPM_LSB] ==
            `MRB_OPM_NORMAL);
         dllResetActive <= (base_configuration[`MRB_OPM_MSB:`MRB_OPM_LSB] ==
            `MRB_OPM_DLLRST);
         // any other pattern is a test or reserved mode
         reservedMode <= (base_configuration[`MRB_OPM_MSB:`MRB_OPM_LSB] != `MRB_OPM_NORMAL)
            && (base_configuration[`MRB_OPM_MSB:`MRB_OPM_LSB] != `MRB_OPM_DLLRST);
         output_drive_select <= extended_configuration[`MRB_EXT_DRIVE_BIT];
      end
   end

   // ----------------------------------------
   // self refresh and DLL state
   // ----------------------------------------
   always @(posedge sysClk) begin
      if (!rstn) begin
         ckeLevel <= 1'b0;
         selfRefresh <= 1'b0;
         dllEnabled <= 1'b0;
      end else begin
         if (ckRise) begin
            ckeLevel <= sCke;
         end
         if (cmdRefresh && ckeLevel && !sCke) begin
            selfRefresh <= 1'b1;
         end else if (ckRise && selfRefresh && sCke) begin
            selfRefresh <= 1'b0;
            dllEnabled <= 1'b1;
         end
         if (cmdLoad && sBank == `MRB_BA_EXT) begin
            dllEnabled <= !sAddr[`MRB_EXT_DLLDIS_BIT];
         end
      end
   end

   // lock counter restarts on every DLL reset load; counts link clocks
   always @(posedge sysClk) begin
      if (!rstn) begin
         lockCount <= 8'h00;
         dllLocked <= 1'b0;
      end else if (!dllEnabled) begin
         lockCount <= 8'h00;
         dllLocked <= 1'b0;
      end else if (cmdLoad && sBank == `MRB_BA_BASE &&
            sAddr[`MRB_OPM_MSB:`MRB_OPM_LSB] == `MRB_OPM_DLLRST) begin
         lockCount <= 8'h00;
         dllLocked <= 1'b0;
      end else if (ckRise && !dllLocked) begin
         if (lockCount == `MRB_DLL_LOCK_CK - 8'h01) begin
            dllLocked <= 1'b1;
         end else begin
            lockCount <= lockCount + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // controller misuse flag
   // ----------------------------------------
   // sticky: the device cannot refuse, it only records the slip
   always @(posedge sysClk) begin
      if (!rstn) begin
         waitCount <= 2'h0;
         protocolError <= 1'b0;
      end else begin
         if (cmdLoad) begin
            waitCount <= `MRB_MODE_WAIT_CK;
            if (burstActive || startPending || waitCount != 2'h0) begin
               protocolError <= 1'b1;
            end
            if (sBank == `MRB_BA_EXT &&
                  sAddr[`MRB_EXT_RSV_MSB:`MRB_EXT_RSV_LSB] != `MRB_EXT_RSV_ZERO) begin
               protocolError <= 1'b1;
            end
         end else if (ckRise && waitCount != 2'h0) begin
            waitCount <= waitCount - 2'h1;
            if (cmdOther) begin
               protocolError <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // burst launch with read latency
   // ----------------------------------------
   always @(posedge sysClk) begin
      if (!rstn) begin
         startDelay <= 3'h0;
         startPending <= 1'b0;
         pendCol <= {`MRB_COL_W{1'b0}};
         pendRead <= 1'b0;
         seqStart <= 1'b0;
         burstIsRead <= 1'b0;
      end else begin
         seqStart <= 1'b0;
         if (cmdRead || cmdWrite) begin
            startPending <= 1'b1;
            pendCol <= sAddr[`MRB_COL_W-1:0];
            pendRead <= cmdRead;
            // first data after the latency, counted in half clocks
            startDelay <= cmdRead ? latencyHalf : `MRB_HALF_WRITE;
         end else if (startPending && halfEdge) begin
            if (startDelay == 3'h1) begin
               startPending <= 1'b0;
               seqStart <= 1'b1;
               burstIsRead <= pendRead;
            end
            startDelay <= startDelay - 3'h1;
         end
      end
   end

   // same length for reads and writes
   mrb_burst_seq mrb_burst_seq_inst (
      .sysClk(sysClk),
      .rstn(rstn),
      .start(seqStart),
      .step(halfEdge),
      .startCol(pendCol),
      .burstLen(burstLen),
      .interleaved(interleaved),
      .column(burstColumn),
      .active(burstActive),
      .last(burstLast)
   );
endmodule

//--- verification/mrb_config_properties.sv
`timescale 1ns/10ps
module mrb_config_checker (
   input wire sysClk,
   input wire rstn,
   input wire csN,
   input wire rasN,
   input wire casN,
   input wire weN,
   input wire bank_select_low,
   input wire bank_select_high,
   input wire [12:0] base_configuration,
   input wire [12:0] extended_configuration,
   input wire [3:0] burstLen,
   input wire interleaved,
   input wire [2:0] latencyHalf,
   input wire normalMode,
   input wire dllResetActive,
   input wire dllEnabled,
   input wire output_drive_select,
   input wire [11:0] burstColumn,
   input wire burstActive,
   input wire burstLast
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   logic [3:0] sinceLoad;
   function automatic [3:0] lenOf(input [2:0] c);
      lenOf = (c != 3'h0 && c < 3'h4) ? 4'h1 << c : 4'h0;
   endfunction
   function automatic [2:0] halfOf(input [2:0] c);
      halfOf = (c == 3'h2) ? 3'h2 : (c == 3'h6) ? 3'h3 : 3'h4;
   endfunction
   // saturates so a stray register change long after any load is caught
   always @(posedge sysClk) begin
      if (!rstn)
         sinceLoad <= 4'hF;
      else if (!csN && !rasN && !casN && !weN && !bank_select_low && !bank_select_high)
         sinceLoad <= 4'h0;
      else if (sinceLoad != 4'hF)
         sinceLoad <= sinceLoad + 4'h1;
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge sysClk); endclocking
   default disable iff (!rstn);
   sequence baseLoaded;
      $changed(base_configuration);
   endsequence
   sequence extLoaded;
      $changed(extended_configuration);
   endsequence
   sequence burstStep;
      burstActive && $past(burstActive) && $changed(burstColumn);
   endsequence
   base_hold_a: assert property (baseLoaded |-> sinceLoad < 4'hA)
      else $error("base register changed without a load");
   len_decode_a: assert property (
      baseLoaded |=> burstLen == lenOf($past(base_configuration[2:0])))
      else $error("burst length decode wrong");
   type_decode_a: assert property (
      baseLoaded |=> interleaved == $past(base_configuration[3]))
      else $error("burst type decode wrong");
   lat_decode_a: assert property (
      baseLoaded |=> latencyHalf == halfOf($past(base_configuration[6:4])))
      else $error("latency decode wrong");
   mode_decode_a: assert property (
      baseLoaded |=> normalMode == ($past(base_configuration[12:7]) == 6'h00)
      && dllResetActive == ($past(base_configuration[12:7]) == 6'h02))
      else $error("operating mode decode wrong");
   ext_decode_a: assert property (
      extLoaded |=> output_drive_select == $past(extended_configuration[1])
      && dllEnabled == !$past(extended_configuration[0]))
      else $error("extended decode wrong");
   block_wrap_a: assert property (
      burstStep |->
      ((burstColumn ^ $past(burstColumn)) & ~{8'h00, burstLen - 4'h1}) == 12'h000)
      else $error("burst left its block");
   seq_order_a: assert property (
      burstStep ##0 !interleaved |->
      ((burstColumn ^ ($past(burstColumn) + 12'h001)) & {8'h00, burstLen - 4'h1}) == 12'h000)
      else $error("sequential step wrong");
   burst_end_a: assert property ($fell(burstActive) |-> ##[0:1] burstLast ##1 !burstLast)
      else $error("burst end pulse wrong");
endmodule
bind mrb_config mrb_config_checker mrb_config_checker_inst (.sysClk, .rstn, .csN, .rasN, .casN,
   .weN, .bank_select_low, .bank_select_high, .base_configuration, .extended_configuration,
   .burstLen, .interleaved, .latencyHalf, .normalMode, .dllResetActive, .dllEnabled,
   .output_drive_select, .burstColumn, .burstActive, .burstLast);

//--- verification/mrb_ctrl_model.sv
`timescale 1ns/10ps
module mrb_ctrl_model (
   input wire sysClk,
   output reg ck,
   output reg cke,
   output reg csN,
   output reg rasN,
   output reg casN,
   output reg weN,
   output reg bank_select_low,
   output reg bank_select_high,
   output reg [12:0] addr
);
   // command clock runs free, as the memory expects
   initial begin
      ck = 1'b0;
      cke = 1'b1;
      {csN, rasN, casN, weN} = 4'hF;
      {bank_select_high, bank_select_low} = 2'h0;
      addr = 13'h0000;
      #37;
      forever #200 ck = ~ck;
   end
   // one command over one ck rise; afterwards the address shows its inverse
   task send(input [3:0] c, input [1:0] ba, input [12:0] a, input k);
      begin
         @(negedge ck);
         @(posedge sysClk);
         {csN, rasN, casN, weN} <= c;
         {bank_select_high, bank_select_low} <= ba;
         addr <= a;
         cke <= k;
         @(negedge ck);
         @(posedge sysClk);
         {csN, rasN, casN, weN} <= 4'hF;
         addr <= ~a;
      end
   endtask
   task load(input [1:0] ba, input [12:0] a);
      begin
         send(4'h0, ba, a, 1'b1);
         repeat (2) @(posedge ck);
      end
   endtask
endmodule

//--- verification/mrb_config_bench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errTotal++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module mrb_config_bench;
   reg sysClk;
   reg rstn;
   wire ck, cke, csN, rasN, casN, weN, bank_select_low, bank_select_high;
   wire [12:0] addr, base_configuration, extended_configuration;
   wire [3:0] burstLen;
   wire [2:0] latencyHalf;
   wire [11:0] burstColumn;
   wire interleaved, normalMode, dllResetActive, reservedMode, dllEnabled, dllLocked;
   wire output_drive_select, selfRefresh, protocolError, burstActive, burstLast, burstIsRead;
   int errTotal, nCompared, cycles, e, bl, t, c;
   realtime tRise;
   reg [12:0] a;
   reg [3:0] len;
   mrb_ctrl_model ctrl (.sysClk, .ck, .cke, .csN, .rasN, .casN, .weN, .bank_select_low,
      .bank_select_high, .addr);
   mrb_config mrb_config_inst (.sysClk, .rstn, .ck, .cke, .csN, .rasN, .casN, .weN,
      .bank_select_low, .bank_select_high, .addr, .base_configuration, .extended_configuration,
      .burstLen, .interleaved, .latencyHalf, .normalMode, .dllResetActive, .reservedMode,
      .dllEnabled, .dllLocked, .output_drive_select, .selfRefresh, .protocolError,
      .burstColumn, .burstActive, .burstLast, .burstIsRead);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   initial begin
      sysClk = 1'b0;
      forever #25 sysClk = ~sysClk;
   end
   always @(posedge ck) tRise = $realtime;
   always @(posedge sysClk) begin
      cycles++;
      if (cycles == 20000) begin
         errTotal++;
         testDone;
      end
   end
   function automatic [11:0] expCol(input [11:0] s, input [3:0] n, input ilv, input [2:0] k);
      reg [11:0] m;
      begin
         m = {8'h00, n - 4'h1};
         expCol = (s & ~m) | ((ilv ? s ^ {9'h000, k} : s + {9'h000, k}) & m);
      end
   endfunction
   task testDone;
      begin
         if (errTotal == 0 && nCompared > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // start time is judged in ck half edges; sync delay allowed 150..350 ns
   task burst(input rd, input [11:0] col, input [3:0] n, input ilv, input int half);
      int i, d;
      realtime r0;
      begin
         ctrl.send(rd ? 4'h5 : 4'h4, 2'($urandom), {1'b0, col}, 1'b1);
         // the command's own ck rise; later rises would hide it
         r0 = tRise;
         i = 0;
         while (burstActive !== 1'b1 && i < 100) begin
            @(negedge sysClk);
            i++;
         end
         d = int'($realtime - r0) - 200 * half;
         `CHK(d >= 150 && d <= 350, 1'b1)
         for (i = 0; i < n; i++) begin
            `CHK(burstColumn, expCol(col, n, ilv, i[2:0]))
            repeat (4) @(negedge sysClk);
         end
         `CHK(burstActive, 1'b0)
         `CHK(burstIsRead, rd)
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      void'($urandom(38));
      repeat (12) @(posedge sysClk);
      rstn <= 1'b1;
      repeat (4) @(posedge sysClk);
      for (e = 0; e < 4; e++) begin
         ctrl.load(2'h1, e[12:0]);
         `CHK(extended_configuration, e[12:0])
         `CHK({output_drive_select, dllEnabled}, {e[1], ~e[0]})
      end
      `CHK(base_configuration, 13'h0000)
      ctrl.send(4'h1, 2'h0, 13'h0000, 1'b0);
      repeat (2) @(posedge ck);
      `CHK(selfRefresh, 1'b1)
      ctrl.send(4'hF, 2'h0, 13'h0000, 1'b1);
      repeat (2) @(posedge ck);
      `CHK({selfRefresh, dllEnabled}, 2'h1)
      ctrl.load(2'h1, 13'h0000);
      ctrl.load(2'h0, 13'h0132);
      `CHK({dllResetActive, normalMode}, 2'h2)
      repeat (188) @(posedge ck);
      `CHK(dllLocked, 1'b0)
      repeat (14) @(posedge ck);
      `CHK(dllLocked, 1'b1)
      for (bl = 0; bl < 4; bl++)
         for (t = 0; t < 2; t++)
            for (c = 0; c < 3; c++) begin
               a = {6'h00, (c == 0) ? 3'h2 : (c == 1) ? 3'h6 : 3'h3, t[0], bl[2:0]};
               len = (bl == 0) ? 4'h0 : 4'h1 << bl;
               ctrl.load(2'h0, a);
               `CHK(base_configuration, a)
               `CHK(burstLen, len)
               `CHK(latencyHalf, 3'(c + 2))
               `CHK({interleaved, normalMode, reservedMode}, {t[0], 2'h2})
               if (bl != 0) begin
                  burst(1'b1, (c == 0) ? 12'hFFF : 12'($urandom), len, t[0], c + 2);
                  burst(1'b0, 12'($urandom), len, t[0], 2);
               end
            end
      `CHK(protocolError, 1'b0)
      testDone;
   end
endmodule
